/* common/ecg_regs.svh */
// Offsets, fields, resets and timing counts of the readout block
`ifndef ECG_REGS_SVH
`define ECG_REGS_SVH

// Register addresses; command byte is {address, read}
`define ADDR_STATUS        7'h01
`define ADDR_INT_MANAGE    7'h04
`define ADDR_RESYNC        7'h09
`define ADDR_BUF_CLEAR     7'h0a
`define ADDR_GENERAL       7'h10
`define ADDR_BEAT_CFG      7'h1d
`define ADDR_BUF_BURST     7'h20
`define ADDR_BUF_READ      7'h21
`define ADDR_BEAT_INTERVAL 7'h25

// Field positions
`define STAT_OVF_BIT       22
`define STAT_BEAT_IRQ_BIT  10
`define CLR_MODE_LSB       4
`define CHAN_EN_BIT        19
`define DETECT_EN_BIT      15
`define INTERVAL_LSB       10
`define TAG_LSB            3
`define SAMPLE_LSB         6

// Reset values
`define INT_MANAGE_RESET   24'h000000
`define GENERAL_RESET      24'h000000
`define BEAT_CFG_RESET     24'h3f2300

// Beat-interval clear modes
`define CLR_ON_STATUS      2'h0
`define CLR_ON_INTERVAL    2'h1
`define CLR_SELF           2'h2

// Sample tags
`define TAG_VALID          3'h0
`define TAG_FAST           3'h1
`define TAG_VALID_EOF      3'h2
`define TAG_FAST_EOF       3'h3
`define TAG_EMPTY          3'h6
`define TAG_OVF            3'h7

// Serial frame edge counts
`define LAST_CMD_EDGE      6'h07
`define CMD_EDGES          6'h08
`define LAST_WORD_EDGE     6'h1f

// Beat-interval LSB time and clock rate
`define CLK_MHZ            50
`define BEAT_LSB_US        8000
`define BEAT_LSB_CYCLES    (`BEAT_LSB_US * `CLK_MHZ)

`endif

/* common/ecg_pkg.sv */
// Types shared by the sample readout block
package ecg_pkg;

   // One converted sample as it arrives from the front end
   typedef struct packed {
      logic [17:0] volt;    // Two's complement voltage
      logic        fast;    // Taken during fast recovery
   } sample_t;

   // Serial transaction phase
   typedef enum logic [1:0] {
      SPI_CMD,
      SPI_READ,
      SPI_WRITE,
      SPI_DONE
   } spi_state_t;

endpackage

/* hdl/two_entry_buffer.sv */
// Two-entry valid/ready buffer on the incoming sample path
`timescale 1ns/1ns
module two_entry_buffer #(
   parameter int WIDTH = 19
) (
   input  wire logic             CLK_IN,
   input  wire logic             RST_N_IN,
   input  wire logic             IN_VALID_IN,
   input  wire logic [WIDTH-1:0] IN_DATA_IN,
   output logic                  IN_READY_OUT,
   output logic                  OUT_VALID_OUT,
   output logic [WIDTH-1:0]      OUT_DATA_OUT,
   input  wire logic             OUT_READY_IN
);

   logic [WIDTH-1:0] entry_reg [2];    // Storage, indexed by slot
   logic             wr_idx_reg;       // Slot for next push
   logic             wr_idx_next;
   logic             rd_idx_reg;       // Slot for next pop
   logic             rd_idx_next;
   logic [1:0]       count_reg;        // Occupied slots
   logic [1:0]       count_next;
   logic             push;
   logic             pop;

   assign IN_READY_OUT  = (count_reg != 2'h2);
   assign OUT_VALID_OUT = (count_reg != 2'h0);
   assign OUT_DATA_OUT  = entry_reg[rd_idx_reg];
   assign push          = IN_VALID_IN & IN_READY_OUT;
   assign pop           = OUT_VALID_OUT & OUT_READY_IN;

   // A stalled drain side fills both slots
   always_comb begin
      wr_idx_next = wr_idx_reg ^ push;
      rd_idx_next = rd_idx_reg ^ pop;
      count_next  = count_reg + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         wr_idx_reg <= 1'b0;
         rd_idx_reg <= 1'b0;
         count_reg  <= 2'h0;
      end else begin
         wr_idx_reg <= wr_idx_next;
         rd_idx_reg <= rd_idx_next;
         count_reg  <= count_next;
      end
   end

   // Data slots need no reset; read only while occupied
   always_ff @(posedge CLK_IN) begin
      if (push) begin
         entry_reg[wr_idx_reg] <= IN_DATA_IN;
      end
   end

endmodule

/* hdl/sample_queue.sv */
// Circular sample queue with overflow detection
`timescale 1ns/1ns
module sample_queue #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
) (
   input  wire logic                   CLK_IN,
   input  wire logic                   RST_N_IN,
   input  wire logic                   CLEAR_IN,
   input  wire logic                   WR_IN,
   input  wire logic [WIDTH-1:0]       WR_DATA_IN,
   input  wire logic                   POP_IN,
   output logic [WIDTH-1:0]            HEAD_OUT,
   output logic [$clog2(DEPTH+1)-1:0]  COUNT_OUT,
   output logic                        OVERFLOW_OUT
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];  // Entries, addressed by pointer
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    wr_ptr_next;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW-1:0]    rd_ptr_next;
   logic [CW-1:0]    count_reg;
   logic [CW-1:0]    count_next;
   logic             ovf_reg;          // Sticky until a clear
   logic             ovf_next;
   logic             do_pop;

   assign HEAD_OUT     = mem_reg[rd_ptr_reg];
   assign COUNT_OUT    = count_reg;
   assign OVERFLOW_OUT = ovf_reg;
   assign do_pop       = POP_IN & (count_reg != '0);

   // A write into a full queue overwrites the oldest word
   always_comb begin
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      count_next  = count_reg;
      ovf_next    = ovf_reg;
      if (CLEAR_IN) begin                                   // RL10
         wr_ptr_next = '0;
         rd_ptr_next = '0;
         count_next  = '0;
         ovf_next    = 1'b0;
      end else begin
         if (WR_IN) begin
            wr_ptr_next = (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (do_pop || (WR_IN && count_reg == FULL)) begin
            rd_ptr_next = (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (WR_IN && !do_pop && count_reg != FULL) begin
            count_next = count_reg + 1'b1;
         end else if (do_pop && !WR_IN) begin
            count_next = count_reg - 1'b1;
         end
         if (WR_IN && !do_pop && count_reg == FULL) begin
            ovf_next = 1'b1;                                // RL23
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         ovf_reg    <= 1'b0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg  <= count_next;
         ovf_reg    <= ovf_next;
      end
   end

   // One storage slot per entry
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge CLK_IN) begin
         if (WR_IN && !CLEAR_IN && wr_ptr_reg == AW'(i)) begin  // RL21
            mem_reg[i] <= WR_DATA_IN;
         end
      end
   end

endmodule

/* hdl/ecg_sample_readout.sv */
// Sample buffer readout, tags and beat interval behind a serial port
`timescale 1ns/1ns
`include "ecg_regs.svh"

// Functional notes
// RL1: Sample is 18-bit left-justified two's complement
// RL2: Three-bit tag sits in word bits 5:3
// RL3: Tag 000 for valid sample, more remain
// RL4: Tag 001 for fast-recovery sample
// RL5: Tag 010 for last valid sample held
// RL6: Tag 011 for last fast-recovery sample
// RL7: Tag 110 when reading an empty buffer
// RL8: Tag 111 on all words after overflow
// RL9: Overflow also shown in status flag
// RL10: Clear or resync empties the buffer
// RL11: Host pauses reads after end-of-data
// RL12: Host drops empty words, no time step
// RL13: Host keeps time step for fast words
// RL14: Interval read-only, 14 bits left-justified
// RL15: Interval holds time between last two beats
// RL16: New beat updates interval, raises interrupt
// RL17: Mode 01 clears interrupt on interval read
// RL18: Mode 00 clears interrupt on status read
// RL19: Mode 10 self-clears after one data cycle
// RL20: Interval counter wraps silently without beats
// RL21: Buffer is 32 entries of 24 bits
// RL22: Pop on edge 32, then every 24
// RL23: Overflow when write pointer laps read
// RL24: Detection needs both enables
// RL25: Reserved tags 100 and 101 never appear
// RL26: Interrupt holds until its clear condition
module ecg_sample_readout #(
   parameter int BEAT_LSB_CYCLES = `BEAT_LSB_CYCLES,
   parameter int DEPTH           = 32
) (
   input  wire logic            CLK_IN,
   input  wire logic            RST_N_IN,
   input  wire logic            SCLK_IN,
   input  wire logic            CSB_N_IN,
   input  wire logic            SDI_IN,
   output logic                 SDO_OUT,
   output logic                 SDO_OE_OUT,
   input  wire logic            SAMPLE_VALID_IN,
   input  wire ecg_pkg::sample_t SAMPLE_IN,
   output logic                 SAMPLE_READY_OUT,
   input  wire logic            R_EVENT_IN,
   output logic                 BEAT_IRQ_OUT,
   output logic                 CHANNEL_RESYNC_OUT,
   output logic                 ECG_CHANNEL_ENABLE_OUT,
   output logic                 BEAT_DETECT_ACTIVE_OUT
);
   import ecg_pkg::*;

   localparam int PW = $clog2(BEAT_LSB_CYCLES + 1);
   localparam logic [PW-1:0] PRESCALE_LAST = PW'(BEAT_LSB_CYCLES - 1);
   localparam int CW = $clog2(DEPTH + 1);

   // Pin synchronisers
   logic             sclk_meta_reg;    // First stage, feeds only the second
   logic             sclk_sync_reg;
   logic             sclk_prev_reg;    // Edge detection history
   logic             csb_meta_reg;
   logic             csb_sync_reg;
   logic             sdi_meta_reg;
   logic             sdi_sync_reg;
   logic             sclk_rise;
   logic             cs_active;

   // Serial engine and configuration
   spi_state_t       state_reg;
   spi_state_t       state_next;
   logic [5:0]       bit_cnt_reg;      // Rising edges so far in this frame; each burst word restarts the count at 8
   logic [5:0]       bit_cnt_next;
   logic [7:0]       cmd_reg;          // {address, read}
   logic [7:0]       cmd_next;
   logic [23:0]      rx_reg;           // Write data shifter
   logic [23:0]      rx_next;
   logic [23:0]      tx_reg;           // Read data shifter, MSB on the pin
   logic [23:0]      tx_next;
   logic             load_reg;         // Fetch the read word next cycle
   logic             load_next;
   logic [23:0]      int_manage_reg;
   logic [23:0]      int_manage_next;
   logic [23:0]      general_reg;
   logic [23:0]      general_next;
   logic [23:0]      beat_cfg_reg;
   logic [23:0]      beat_cfg_next;
   logic             resync_reg;       // One-cycle resync strobe
   logic             resync_next;
   logic             fifo_pop;
   logic             buf_clear;
   logic             status_rd_done;
   logic             interval_rd_done;
   logic [6:0]       addr;
   logic             is_fifo;
   logic [23:0]      read_word;
   logic [2:0]       tag;

   // Beat interval
   logic [PW-1:0]    prescale_reg;     // Counts system clocks per LSB
   logic [PW-1:0]    prescale_next;
   logic [13:0]      interval_cnt_reg; // Running interval since last beat
   logic [13:0]      interval_cnt_next;
   logic [13:0]      interval_reg;     // Last completed interval
   logic [13:0]      interval_next;
   logic             beat_irq_reg;
   logic             beat_irq_next;
   logic [1:0]       clear_mode;
   logic             detect_active;
   logic             irq_clear_hit;

   // Sample path
   sample_t          buf_sample;
   logic             buf_valid;
   logic             fifo_accept;
   logic             fifo_wr;
   logic [23:0]      fifo_head;
   logic [CW-1:0]    fifo_count;
   logic             fifo_ovf;
   logic             fifo_empty;

   // Two flip-flops per pin, a third on SCLK for edge detection
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         sclk_meta_reg <= 1'b0;
         sclk_sync_reg <= 1'b0;
         sclk_prev_reg <= 1'b0;
         csb_meta_reg  <= 1'b1;
         csb_sync_reg  <= 1'b1;
         sdi_meta_reg  <= 1'b0;
         sdi_sync_reg  <= 1'b0;
      end else begin
         sclk_meta_reg <= SCLK_IN;
         sclk_sync_reg <= sclk_meta_reg;
         sclk_prev_reg <= sclk_sync_reg;
         csb_meta_reg  <= CSB_N_IN;
         csb_sync_reg  <= csb_meta_reg;
         sdi_meta_reg  <= SDI_IN;
         sdi_sync_reg  <= sdi_meta_reg;
      end
   end

   assign sclk_rise  = sclk_sync_reg & ~sclk_prev_reg;
   assign cs_active  = ~csb_sync_reg;
   assign addr       = cmd_reg[7:1];
   assign is_fifo    = (addr == `ADDR_BUF_BURST) || (addr == `ADDR_BUF_READ);
   assign fifo_empty = (fifo_count == '0);
   assign clear_mode = int_manage_reg[`CLR_MODE_LSB +: 2];
   assign ECG_CHANNEL_ENABLE_OUT = general_reg[`CHAN_EN_BIT];
   assign detect_active = beat_cfg_reg[`DETECT_EN_BIT] & general_reg[`CHAN_EN_BIT];  // RL24
   assign BEAT_DETECT_ACTIVE_OUT = detect_active;

   // Tag choice; only the six defined codes can be produced
   always_comb begin
      if (fifo_ovf) begin
         tag = `TAG_OVF;                                    // RL8
      end else if (fifo_empty) begin
         tag = `TAG_EMPTY;                                  // RL7
      end else if (fifo_head[`TAG_LSB]) begin
         tag = (fifo_count == CW'(1)) ? `TAG_FAST_EOF : `TAG_FAST;    // RL4 RL6
      end else begin
         tag = (fifo_count == CW'(1)) ? `TAG_VALID_EOF : `TAG_VALID;  // RL3 RL5
      end
   end

   // Read word per address
   always_comb begin
      read_word = 24'h000000;
      case (addr)
         `ADDR_STATUS: begin
            read_word[`STAT_OVF_BIT]      = fifo_ovf;       // RL9
            read_word[`STAT_BEAT_IRQ_BIT] = beat_irq_reg;
         end
         `ADDR_INT_MANAGE:    read_word = int_manage_reg;
         `ADDR_GENERAL:       read_word = general_reg;
         `ADDR_BEAT_CFG:      read_word = beat_cfg_reg;
         `ADDR_BUF_BURST,
         `ADDR_BUF_READ: begin
            // Empty reads carry no voltage; overflow keeps the data
            read_word[23:`SAMPLE_LSB]       = fifo_empty ? 18'h00000 : fifo_head[23:`SAMPLE_LSB];
            read_word[`TAG_LSB +: 3]        = tag;          // RL1 RL2 RL25
         end
         `ADDR_BEAT_INTERVAL: begin
            read_word[23:`INTERVAL_LSB]     = interval_reg; // RL14
         end
         default:             read_word = 24'h000000;
      endcase
   end

   // Command byte, then 24-bit words
   always_comb begin
      state_next       = state_reg;
      bit_cnt_next     = bit_cnt_reg;
      cmd_next         = cmd_reg;
      rx_next          = rx_reg;
      tx_next          = tx_reg;
      load_next        = 1'b0;
      int_manage_next  = int_manage_reg;
      general_next     = general_reg;
      beat_cfg_next    = beat_cfg_reg;
      resync_next      = 1'b0;
      fifo_pop         = 1'b0;
      buf_clear        = 1'b0;
      status_rd_done   = 1'b0;
      interval_rd_done = 1'b0;
      // Fetch one cycle after the edge so a burst sees the popped head
      if (load_reg) begin
         tx_next = read_word;
      end
      if (!cs_active) begin
         // Deselect aborts any frame; partial words commit nothing
         state_next   = SPI_CMD;
         bit_cnt_next = 6'h00;
      end else if (sclk_rise) begin
         case (state_reg)
            SPI_CMD: begin
               cmd_next     = {cmd_reg[6:0], sdi_sync_reg};
               bit_cnt_next = bit_cnt_reg + 6'h01;
               if (bit_cnt_reg == `LAST_CMD_EDGE) begin
                  if (cmd_next[0]) begin
                     state_next = SPI_READ;
                     load_next  = 1'b1;
                  end else begin
                     state_next = SPI_WRITE;
                  end
               end
            end
            SPI_READ: begin
               tx_next      = {tx_reg[22:0], 1'b0};
               bit_cnt_next = bit_cnt_reg + 6'h01;
               if (bit_cnt_reg == `LAST_WORD_EDGE) begin
                  fifo_pop         = is_fifo & ~fifo_empty;            // RL22
                  status_rd_done   = (addr == `ADDR_STATUS);
                  interval_rd_done = (addr == `ADDR_BEAT_INTERVAL);
                  if (addr == `ADDR_BUF_BURST) begin
                     bit_cnt_next = `CMD_EDGES;                        // RL22
                     load_next    = 1'b1;
                  end else begin
                     state_next = SPI_DONE;
                  end
               end
            end
            SPI_WRITE: begin
               rx_next      = {rx_reg[22:0], sdi_sync_reg};
               bit_cnt_next = bit_cnt_reg + 6'h01;
               if (bit_cnt_reg == `LAST_WORD_EDGE) begin
                  state_next = SPI_DONE;
                  // Read-only registers ignore writes
                  case (addr)
                     `ADDR_INT_MANAGE: int_manage_next = rx_next;
                     `ADDR_GENERAL:    general_next    = rx_next;
                     `ADDR_BEAT_CFG:   beat_cfg_next   = rx_next;
                     `ADDR_BUF_CLEAR:  buf_clear       = 1'b1;      // RL10
                     `ADDR_RESYNC: begin
                        buf_clear   = 1'b1;                         // RL10
                        resync_next = 1'b1;
                     end
                     default: ;
                  endcase
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         state_reg      <= SPI_CMD;
         bit_cnt_reg    <= 6'h00;
         cmd_reg        <= 8'h00;
         rx_reg         <= 24'h000000;
         tx_reg         <= 24'h000000;
         load_reg       <= 1'b0;
         int_manage_reg <= `INT_MANAGE_RESET;
         general_reg    <= `GENERAL_RESET;
         beat_cfg_reg   <= `BEAT_CFG_RESET;
         resync_reg     <= 1'b0;
      end else begin
         state_reg      <= state_next;
         bit_cnt_reg    <= bit_cnt_next;
         cmd_reg        <= cmd_next;
         rx_reg         <= rx_next;
         tx_reg         <= tx_next;
         load_reg       <= load_next;
         int_manage_reg <= int_manage_next;
         general_reg    <= general_next;
         beat_cfg_reg   <= beat_cfg_next;
         resync_reg     <= resync_next;
      end
   end

   assign SDO_OUT            = tx_reg[23];
   assign SDO_OE_OUT         = cs_active;
   assign CHANNEL_RESYNC_OUT = resync_reg;

   // Clear source per mode; mode 11 acts as status clear
   always_comb begin
      case (clear_mode)
         `CLR_ON_INTERVAL: irq_clear_hit = interval_rd_done;   // RL17
         `CLR_SELF:        irq_clear_hit = fifo_wr;            // RL19
         default:          irq_clear_hit = status_rd_done;     // RL18
      endcase
   end

   // Interval in LSB ticks; a beat wins over a same-cycle clear
   always_comb begin
      prescale_next     = prescale_reg;
      interval_cnt_next = interval_cnt_reg;
      interval_next     = interval_reg;
      beat_irq_next     = beat_irq_reg;
      if (!detect_active) begin
         prescale_next     = '0;
         interval_cnt_next = 14'h0000;
      end else if (R_EVENT_IN) begin
         interval_next     = interval_cnt_reg;                  // RL15 RL16
         prescale_next     = '0;
         interval_cnt_next = 14'h0000;
      end else if (prescale_reg == PRESCALE_LAST) begin
         prescale_next     = '0;
         interval_cnt_next = interval_cnt_reg + 14'h0001;       // RL20
      end else begin
         prescale_next     = prescale_reg + 1'b1;
      end
      if (detect_active && R_EVENT_IN) begin
         beat_irq_next = 1'b1;                                  // RL16
      end else if (irq_clear_hit) begin
         beat_irq_next = 1'b0;                                  // RL26
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         prescale_reg     <= '0;
         interval_cnt_reg <= 14'h0000;
         interval_reg     <= 14'h0000;
         beat_irq_reg     <= 1'b0;
      end else begin
         prescale_reg     <= prescale_next;
         interval_cnt_reg <= interval_cnt_next;
         interval_reg     <= interval_next;
         beat_irq_reg     <= beat_irq_next;
      end
   end

   assign BEAT_IRQ_OUT = beat_irq_reg;

   // Samples wait while the channel is off or a clear runs
   assign fifo_accept = general_reg[`CHAN_EN_BIT] & ~buf_clear;
   assign fifo_wr     = buf_valid & fifo_accept;

   two_entry_buffer #(
      .WIDTH         ($bits(sample_t))
   ) u_in_buffer (
      .CLK_IN        (CLK_IN),
      .RST_N_IN      (RST_N_IN),
      .IN_VALID_IN   (SAMPLE_VALID_IN),
      .IN_DATA_IN    (SAMPLE_IN),
      .IN_READY_OUT  (SAMPLE_READY_OUT),
      .OUT_VALID_OUT (buf_valid),
      .OUT_DATA_OUT  (buf_sample),
      .OUT_READY_IN  (fifo_accept)
   );

   // Stored word keeps the fast bit in the tag field
   sample_queue #(
      .WIDTH        (24),
      .DEPTH        (DEPTH)
   ) u_queue (
      .CLK_IN       (CLK_IN),
      .RST_N_IN     (RST_N_IN),
      .CLEAR_IN     (buf_clear),
      .WR_IN        (fifo_wr),
      .WR_DATA_IN   ({buf_sample.volt, 2'b00, buf_sample.fast, 3'b000}),  // RL1
      .POP_IN       (fifo_pop),
      .HEAD_OUT     (fifo_head),
      .COUNT_OUT    (fifo_count),
      .OVERFLOW_OUT (fifo_ovf)
   );

endmodule

/* verification/ecg_sample_readout_props.sv */
// Port checker for the sample readout block
`timescale 1ns/1ns
module ecg_sample_readout_props (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic CSB_N_IN,
   input wire logic R_EVENT_IN,
   input wire logic BEAT_IRQ_OUT,
   input wire logic CHANNEL_RESYNC_OUT,
   input wire logic ECG_CHANNEL_ENABLE_OUT,
   input wire logic BEAT_DETECT_ACTIVE_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   // Select idle for 8 clocks
   sequence s_idle; CSB_N_IN[*8]; endsequence
   property p_set; R_EVENT_IN && BEAT_DETECT_ACTIVE_OUT |=> BEAT_IRQ_OUT; endproperty
   a_set: assert property (p_set) else $error("irq not set");
   property p_cause;
      $rose(BEAT_IRQ_OUT) |-> $past(R_EVENT_IN && BEAT_DETECT_ACTIVE_OUT);
   endproperty
   a_cause: assert property (p_cause) else $error("irq without beat");
   property p_both; BEAT_DETECT_ACTIVE_OUT |-> ECG_CHANNEL_ENABLE_OUT; endproperty
   a_both: assert property (p_both) else $error("detect without channel");
   property p_off; !BEAT_DETECT_ACTIVE_OUT && !BEAT_IRQ_OUT |=> !BEAT_IRQ_OUT; endproperty
   a_off: assert property (p_off) else $error("irq while idle");
   property p_hold; s_idle ##0 BEAT_IRQ_OUT && !ECG_CHANNEL_ENABLE_OUT |=> BEAT_IRQ_OUT; endproperty
   a_hold: assert property (p_hold) else $error("irq dropped");
   // Clears follow a read frame or a stored sample
   property p_drop;
      $fell(BEAT_IRQ_OUT) |-> $past(!CSB_N_IN, 6) || $past(ECG_CHANNEL_ENABLE_OUT, 2);
   endproperty
   a_drop: assert property (p_drop) else $error("irq cleared early");
   property p_pulse; CHANNEL_RESYNC_OUT |=> !CHANNEL_RESYNC_OUT; endproperty
   a_pulse: assert property (p_pulse) else $error("resync too long");
   property p_sync; CHANNEL_RESYNC_OUT |-> $past(!CSB_N_IN, 6); endproperty
   a_sync: assert property (p_sync) else $error("resync outside frame");
endmodule
bind ecg_sample_readout ecg_sample_readout_props u_props (.CLK_IN(CLK_IN),
   .RST_N_IN(RST_N_IN), .CSB_N_IN(CSB_N_IN), .R_EVENT_IN(R_EVENT_IN),
   .BEAT_IRQ_OUT(BEAT_IRQ_OUT), .CHANNEL_RESYNC_OUT(CHANNEL_RESYNC_OUT),
   .ECG_CHANNEL_ENABLE_OUT(ECG_CHANNEL_ENABLE_OUT),
   .BEAT_DETECT_ACTIVE_OUT(BEAT_DETECT_ACTIVE_OUT));

/* verification/spi_host_model.sv */
// Host model: serial frames of a command byte and data words
`timescale 1ns/1ns
`include "ecg_regs.svh"
module spi_host_model (
   input  wire logic CLK_IN,
   input  wire logic SDO_IN,
   output logic      SCLK_OUT = 1'b0,
   output logic      CSB_N_OUT = 1'b1,
   output logic      SDI_OUT = 1'b0
);
   int steps = 0; // Host record time base
   // Clock idles low; the last two words come back
   task automatic xfer(input logic [7:0] c, input logic [23:0] w, input int n,
                       output logic [47:0] r);
      logic [31:0] sh;
      sh = {c, w};
      r = '0;
      CSB_N_OUT = 1'b0;
      for (int i = 0; i < 8 + 24 * n; i++) begin
         SDI_OUT = sh[31];
         sh = sh << 1;
         repeat (4) @(negedge CLK_IN);
         SCLK_OUT = 1'b1;
         r = {r[46:0], SDO_IN};
         repeat (4) @(negedge CLK_IN);
         SCLK_OUT = 1'b0;
      end
      repeat (4) @(negedge CLK_IN);
      CSB_N_OUT = 1'b1;
      SDI_OUT = ~SDI_OUT; // Released line shows no stale level
      repeat (4) @(negedge CLK_IN);
      // Empty words take no time step
      if (c == {`ADDR_BUF_READ, 1'b1} && r[5:3] != `TAG_EMPTY) steps++;
   endtask
endmodule

/* verification/ecg_sample_readout_tb_top.sv */
// Bench for the sample readout block
`timescale 1ns/1ns
`include "ecg_regs.svh"
module ecg_sample_readout_tb_top;
   import ecg_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, valid = 1'b0, r_ev = 1'b0;
   logic        sclk, csb_n, sdi, sdo, ready, irq;
   sample_t     smp = '0;
   logic [47:0] rd;
   int          failures = 0, checked = 0;
   localparam logic [23:0] EMPTY_WORD = {18'h0, `TAG_EMPTY, 3'h0};
   always #10 clk = ~clk;
   ecg_sample_readout #(.BEAT_LSB_CYCLES(20)) u_dut (.CLK_IN(clk), .RST_N_IN(rst_n),
      .SCLK_IN(sclk), .CSB_N_IN(csb_n), .SDI_IN(sdi), .SDO_OUT(sdo), .SDO_OE_OUT(),
      .SAMPLE_VALID_IN(valid), .SAMPLE_IN(smp), .SAMPLE_READY_OUT(ready),
      .R_EVENT_IN(r_ev), .BEAT_IRQ_OUT(irq), .CHANNEL_RESYNC_OUT(),
      .ECG_CHANNEL_ENABLE_OUT(), .BEAT_DETECT_ACTIVE_OUT());
   spi_host_model u_host (.CLK_IN(clk), .SDO_IN(sdo), .SCLK_OUT(sclk), .CSB_N_OUT(csb_n),
      .SDI_OUT(sdi));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task automatic ci(input logic e);
      chk({23'h0, irq}, {23'h0, e});
   endtask
   task automatic finish_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic rq(input logic [6:0] a, input int n = 1);
      u_host.xfer({a, 1'b1}, 24'h0, n, rd);
   endtask
   task automatic wq(input logic [6:0] a, input logic [23:0] d);
      u_host.xfer({a, 1'b0}, d, 1, rd);
   endtask
   // Hold a sample until taken
   task automatic push(input logic [17:0] v, input logic f);
      int k;
      smp = '{v, f};
      valid = 1'b1;
      for (k = 0; k < 50 && ready !== 1'b1; k++) @(negedge clk);
      if (k == 50) begin
         failures++;
         finish_test();
      end
      @(negedge clk);
      valid = 1'b0;
   endtask
   // One-cycle beat pulse
   task automatic beat;
      r_ev = 1'b1;
      @(negedge clk);
      r_ev = 1'b0;
      @(negedge clk);
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      rq(`ADDR_BUF_READ);
      chk(rd[23:0], EMPTY_WORD);
      wq(`ADDR_BEAT_INTERVAL, 24'hfffc00);
      rq(`ADDR_BEAT_INTERVAL);
      chk(rd[23:0], 24'h0);
      wq(`ADDR_GENERAL, 24'h80000);
      push(18'h2abcd, 1'b0);
      push(18'h15555, 1'b1);
      push(18'h3ffff, 1'b0);
      rq(`ADDR_BUF_READ);
      chk(rd[23:0], {18'h2abcd, `TAG_VALID, 3'h0});
      rq(`ADDR_BUF_BURST, 2);
      chk(rd[47:24], {18'h15555, `TAG_FAST, 3'h0});
      chk(rd[23:0], {18'h3ffff, `TAG_VALID_EOF, 3'h0});
      push(18'h00001, 1'b1);
      rq(`ADDR_BUF_READ);
      chk(rd[23:0], {18'h00001, `TAG_FAST_EOF, 3'h0});
      rq(`ADDR_BUF_READ);
      chk(rd[23:0], EMPTY_WORD);
      for (int i = 0; i < 32; i++) push(18'(i), 1'b0);
      rq(`ADDR_STATUS);
      chk(rd[23:0], 24'h0);
      push(18'h00fff, 1'b0);
      rq(`ADDR_STATUS);
      chk(rd[23:0], 24'h400000);
      rq(`ADDR_BUF_READ);
      chk({21'h0, rd[5:3]}, {21'h0, `TAG_OVF});
      wq(`ADDR_BUF_CLEAR, 24'h0);
      rq(`ADDR_STATUS);
      chk(rd[23:0], 24'h0);
      push(18'h00002, 1'b0);
      wq(`ADDR_RESYNC, 24'h0);
      rq(`ADDR_BUF_READ);
      chk(rd[23:0], EMPTY_WORD);
      chk(24'(u_host.steps), 24'h3);
      $display("tags test done");
      wq(`ADDR_BEAT_CFG, 24'h3fa300);
      beat();
      repeat (200) @(negedge clk);
      beat();
      ci(1'b1);
      rq(`ADDR_BEAT_INTERVAL);
      chk(rd[23:0], 24'h2800);
      ci(1'b1);
      rq(`ADDR_STATUS);
      chk(rd[23:0], 24'h400);
      ci(1'b0);
      wq(`ADDR_INT_MANAGE, 24'h10);
      beat();
      rq(`ADDR_STATUS);
      ci(1'b1);
      rq(`ADDR_BEAT_INTERVAL);
      ci(1'b0);
      wq(`ADDR_INT_MANAGE, 24'h20);
      beat();
      wq(`ADDR_GENERAL, 24'h0);
      repeat (8) @(negedge clk);
      ci(1'b1);
      wq(`ADDR_GENERAL, 24'h80000);
      push(18'h00003, 1'b0);
      repeat (4) @(negedge clk);
      ci(1'b0);
      $display("beat test done");
      finish_test();
   end
endmodule
